/* File: src/icytm_pkg.sv */
// Shared constants and types for the isochronous cycle timer and monitor.
// Assumes one 50 MHz core clock and a 12-bit register address space.
package icytm_pkg;

  // Register offsets
  localparam logic [11:0] ICYTM_CFG_OFS  = 12'h008; // Configuration word
  localparam logic [11:0] ICYTM_CTL_OFS  = 12'h00C; // Control word
  localparam logic [11:0] ICYTM_STS_OFS  = 12'h010; // Event flags, W1C
  localparam logic [11:0] ICYTM_TIM_OFS  = 12'h014; // Cycle time, host view
  localparam logic [11:0] ICYTM_TIM2_OFS = 12'h200; // Cycle time, bus view

  // Field positions
  localparam int ICYTM_CFG_SRC_BIT = 21; // Cycle source select
  localparam int ICYTM_CTL_EN_BIT  = 0;  // Cycle timer enable
  localparam int ICYTM_CTL_MAS_BIT = 1;  // Cycle master select
  localparam int ICYTM_STS_CS_BIT  = 0;  // Cycle started
  localparam int ICYTM_STS_CL_BIT  = 1;  // Cycle lost
  localparam int ICYTM_STS_CD_BIT  = 2;  // Cycle done

  // Field widths and wrap points
  localparam int          ICYTM_OFF_W    = 12;
  localparam int          ICYTM_CYC_W    = 13;
  localparam int          ICYTM_SEC_W    = 7;
  localparam logic [11:0] ICYTM_OFF_LAST = 12'hBFF; // 3071
  localparam logic [12:0] ICYTM_CYC_LAST = 13'h1F3F; // 7999

  // Offset rate from the core clock, both in kHz
  localparam int ICYTM_CORE_KHZ = 50000;
  localparam int ICYTM_OFF_KHZ  = 24576;
  localparam logic [15:0] ICYTM_ACC_MOD = 16'(ICYTM_CORE_KHZ);
  localparam logic [15:0] ICYTM_ACC_INC = 16'(ICYTM_OFF_KHZ);

  // Packet code of a cycle-start packet
  localparam logic [3:0] ICYTM_TCODE_CS = 4'h8;

  // Reset values
  localparam logic [31:0] ICYTM_TIM_RST = 32'h0000_0000;
  localparam logic [2:0]  ICYTM_STS_RST = 3'h0;

  // Cycle time layout
  typedef struct packed {
    logic [ICYTM_SEC_W-1:0] sec;
    logic [ICYTM_CYC_W-1:0] cyc;
    logic [ICYTM_OFF_W-1:0] off;
  } icytm_time_t;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } icytm_req_t;

  // Monitor states, Gray along wait -> iso -> done
  typedef enum logic [1:0] {
    ICYTM_MON_WAIT = 2'b00,
    ICYTM_MON_ISO  = 2'b01,
    ICYTM_MON_DONE = 2'b11
  } icytm_mon_t;

endpackage : icytm_pkg

/* File: src/icytm_edge_sync.sv */
// Two-flop synchroniser with rising-edge pulse output.
// Assumes an asynchronous level input and the core clock.
`timescale 1ns/1ps
`default_nettype none
module icytm_edge_sync (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_async,
  output logic      o_rise
);
  logic meta_q;  // First stage, read only by sync_q
  logic sync_q;  // Second stage
  logic last_q;  // Previous synced level

  // Sync chain and edge history
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      last_q <= sync_q;
      o_rise <= sync_q & ~last_q;
    end
  end
endmodule : icytm_edge_sync
`default_nettype wire

/* File: src/icytm_core.sv */
// Isochronous cycle timer and cycle monitor of a serial-bus link.
// Assumes receiver, transmitter and host port on the 50 MHz core clock;
// only the external 8 kHz tick arrives from outside the clock domain.
//
// Functional notes
// - Low 12 bits count offset modulo 3072 with internal source
// - Next 13 bits count 125 us cycles
// - Top 7 bits count seconds
// - Timer readable at 200h and 14h
// - External tick bumps cycle, clears offset
// - Enable clear holds the timer stopped
// - Internal source advances offset at 24.576 MHz
// - Non-master loads timer from received cycle-start
// - Cycle-start sent as master or received as non-master sets started flag
// - Missing expected cycle-start sets lost flag
// - Isochronous period complete sets done flag
// - Master bit makes transmitter send cycle-starts
// - Cycle-start goes to timer as non-master, never to queue
`timescale 1ns/1ps
`default_nettype none
module icytm_core
  import icytm_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // Host register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  output logic             o_reg_ack,
  // External 8 kHz tick pin
  input  wire logic        i_external_cycle_tick_in,
  // Receiver side
  input  wire logic        i_rx_pkt_valid,
  input  wire logic [3:0]  i_rx_tcode,
  input  wire logic [31:0] i_rx_quad,
  output logic             o_general_receive_queue_push,
  output logic      [31:0] o_general_receive_queue_data,
  // Transmitter side
  input  wire logic        i_tx_cs_sent,
  input  wire logic        i_iso_gap,
  output logic             o_tx_cs_req,
  // Live timer and flags
  output logic      [31:0] o_cycle_time,
  output logic      [2:0]  o_cycle_flags
);

  // Request bundle
  icytm_req_t req;
  assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr,
                 wdata: i_reg_wdata};

  // Registers
  icytm_time_t      tim_q, tim_d;   // Cycle time
  logic             src_q;          // Cycle source select
  logic             en_q;           // Cycle timer enable
  logic             mas_q;          // Cycle master select
  logic [2:0]       sts_q, sts_d;   // Sticky event flags
  logic [15:0]      acc_q, acc_d;   // Offset rate accumulator
  icytm_mon_t       mon_q, mon_d;   // Monitor state
  logic             req_q;          // Cycle-start request out
  logic             push_q;         // Queue push out
  logic [31:0]      qdat_q;         // Queue data out
  logic [31:0]      rdat_q;         // Read data out
  logic             ack_q;          // Access acknowledge

  // Decodes
  wire hit_cfg  = req.addr == ICYTM_CFG_OFS;
  wire hit_ctl  = req.addr == ICYTM_CTL_OFS;
  wire hit_sts  = req.addr == ICYTM_STS_OFS;
  wire hit_tim  = (req.addr == ICYTM_TIM_OFS) ||
                  (req.addr == ICYTM_TIM2_OFS);
  wire wr_tim   = req.wr & hit_tim;

  // External tick, synchronised to a one-cycle pulse
  logic tick_rise;
  icytm_edge_sync u_tick (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_external_cycle_tick_in),
    .o_rise     (tick_rise)
  );

  // Fractional divider: 24.576 MHz enable out of 50 MHz
  wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, ICYTM_ACC_INC};
  wire        off_en  = en_q & (acc_sum >= {1'b0, ICYTM_ACC_MOD});
  always_comb begin
    if (!en_q)
      acc_d = acc_q;
    else if (off_en)
      acc_d = 16'(acc_sum - {1'b0, ICYTM_ACC_MOD});
    else
      acc_d = acc_sum[15:0];
  end

  // Received packet classification
  wire rx_cs    = i_rx_pkt_valid & (i_rx_tcode == ICYTM_TCODE_CS);
  wire rx_other = i_rx_pkt_valid & ~rx_cs;
  // Only a non-master follows the bus cycle master
  wire rx_load  = rx_cs & ~mas_q & en_q;

  // Cycle boundaries from each source
  wire off_wrap = off_en & ~src_q & (tim_q.off == ICYTM_OFF_LAST);
  wire ext_cyc  = en_q & src_q & tick_rise;
  wire cyc_step = off_wrap | ext_cyc;
  wire cyc_wrap = cyc_step & (tim_q.cyc == ICYTM_CYC_LAST);

  // Next cycle time
  always_comb begin
    tim_d = tim_q;
    if (wr_tim) begin
      // Host write of the whole word
      tim_d = icytm_time_t'(req.wdata);
    end else if (rx_load) begin
      // Take time and offset from the cycle-start quadlet
      tim_d = icytm_time_t'(i_rx_quad);
    end else if (!en_q) begin
      // Stopped
      tim_d = tim_q;
    end else if (ext_cyc) begin
      tim_d.off = '0;
    end else if (off_en) begin
      if (tim_q.off == ICYTM_OFF_LAST)
        // External mode parks at the last count until the tick
        tim_d.off = src_q ? ICYTM_OFF_LAST : '0;
      else
        tim_d.off = tim_q.off + 12'h001;
    end
    if (!wr_tim && !rx_load && cyc_step) begin
      if (cyc_wrap) begin
        tim_d.cyc = '0;
        tim_d.sec = tim_q.sec + 7'h01;
      end else begin
        tim_d.cyc = tim_q.cyc + 13'h0001;
      end
    end
  end

  // Cycle-start event, sent or received
  wire cs_seen = (i_tx_cs_sent & mas_q) | (rx_cs & ~mas_q);

  // Monitor: a boundary with no cycle-start since the last one is a loss
  wire lost_ev = cyc_step & (mon_q == ICYTM_MON_WAIT);
  wire done_ev = i_iso_gap & (mon_q == ICYTM_MON_ISO);
  always_comb begin
    case (mon_q)
      ICYTM_MON_WAIT: mon_d = cs_seen ? ICYTM_MON_ISO : ICYTM_MON_WAIT;
      ICYTM_MON_ISO:  mon_d = cyc_step ? ICYTM_MON_WAIT :
                              (done_ev ? ICYTM_MON_DONE : ICYTM_MON_ISO);
      ICYTM_MON_DONE: mon_d = cyc_step ? ICYTM_MON_WAIT : ICYTM_MON_DONE;
      default:        mon_d = ICYTM_MON_WAIT;
    endcase
    // A cycle-start in the boundary cycle still counts
    if (cs_seen)
      mon_d = ICYTM_MON_ISO;
    if (!en_q)
      mon_d = ICYTM_MON_ISO; // Disarmed while stopped
  end

  // Sticky flags: set wins over a host write-one clear
  wire [2:0] sts_set = {done_ev, lost_ev & en_q, cs_seen};
  wire [2:0] sts_clr = (req.wr & hit_sts) ? req.wdata[2:0] : 3'h0;
  assign sts_d = (sts_q & ~sts_clr) | sts_set;

  // Read mux
  wire [31:0] rd_mux =
      hit_tim ? tim_q :
      hit_cfg ? (32'h0000_0000 | (32'(src_q) << ICYTM_CFG_SRC_BIT)) :
      hit_ctl ? (32'h0000_0000 | (32'(en_q)  << ICYTM_CTL_EN_BIT) |
                                 (32'(mas_q) << ICYTM_CTL_MAS_BIT)) :
      hit_sts ? {29'h0000_0000, sts_q} :
      32'h0000_0000;

  // Control registers
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      src_q <= 1'b0;
      en_q  <= 1'b0;
      mas_q <= 1'b0;
    end else if (req.wr) begin
      if (hit_cfg)
        src_q <= req.wdata[ICYTM_CFG_SRC_BIT];
      if (hit_ctl) begin
        en_q  <= req.wdata[ICYTM_CTL_EN_BIT];
        mas_q <= req.wdata[ICYTM_CTL_MAS_BIT];
      end
    end
  end

  // Timer, divider, monitor and flags
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      tim_q <= icytm_time_t'(ICYTM_TIM_RST);
      acc_q <= 16'h0000;
      mon_q <= ICYTM_MON_ISO;
      sts_q <= ICYTM_STS_RST;
    end else begin
      tim_q <= tim_d;
      acc_q <= acc_d;
      mon_q <= mon_d;
      sts_q <= sts_d;
    end
  end

  // Transmitter request at each cycle boundary while master
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst)
      req_q <= 1'b0;
    else
      req_q <= mas_q & cyc_step;
  end

  // Non cycle-start packets go on to the receive queue
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      push_q <= 1'b0;
      qdat_q <= 32'h0000_0000;
    end else begin
      push_q <= rx_other;
      qdat_q <= rx_other ? i_rx_quad : qdat_q;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rdat_q <= 32'h0000_0000;
      ack_q  <= 1'b0;
    end else begin
      ack_q  <= req.wr | req.rd;
      rdat_q <= req.rd ? rd_mux : rdat_q;
    end
  end

  // Outputs straight from flops
  assign o_reg_rdata                  = rdat_q;
  assign o_reg_ack                    = ack_q;
  assign o_general_receive_queue_push = push_q;
  assign o_general_receive_queue_data = qdat_q;
  assign o_tx_cs_req                  = req_q;
  assign o_cycle_time                 = tim_q;
  assign o_cycle_flags                = sts_q;

endmodule : icytm_core
`default_nettype wire

/* File: tb/icytm_properties.sv */
// Port checker of the cycle timer and monitor, bound to icytm_core.
// Assumes one core clock and the active-low synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module icytm_checker
  import icytm_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        o_reg_ack,
  input wire logic        i_external_cycle_tick_in,
  input wire logic        i_rx_pkt_valid,
  input wire logic [3:0]  i_rx_tcode,
  input wire logic [31:0] i_rx_quad,
  input wire logic        o_general_receive_queue_push,
  input wire logic [31:0] o_general_receive_queue_data,
  input wire logic        i_tx_cs_sent,
  input wire logic        i_iso_gap,
  input wire logic        o_tx_cs_req,
  input wire logic [31:0] o_cycle_time,
  input wire logic [2:0]  o_cycle_flags
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire [11:0] off = o_cycle_time[11:0];
  wire [12:0] cyc = o_cycle_time[24:12];
  wire [6:0]  sec = o_cycle_time[31:25];
  // Received packet is a cycle-start
  wire        cs_rx = i_rx_pkt_valid && i_rx_tcode == ICYTM_TCODE_CS;
  // No host write or packet load, so only counting may move the timer
  wire        idle = i_nrst && !i_reg_wr && !i_rx_pkt_valid;
  property p_ack; (i_reg_rd || i_reg_wr) |=> o_reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_rd; i_reg_rd && !i_reg_wr && (i_reg_addr == ICYTM_TIM_OFS ||
    i_reg_addr == ICYTM_TIM2_OFS) |=> o_reg_rdata == $past(o_cycle_time);
  endproperty
  a_rd: assert property (p_rd) else $error("bad timer read");
  property p_step; $past(idle) |-> off == $past(off) ||
    off == $past(off) + 12'h1 || off == 12'h0; endproperty
  a_step: assert property (p_step) else $error("offset jump");
  property p_wrap; $past(idle) && off < $past(off) |-> off == 12'h0 &&
    cyc == (($past(cyc) == ICYTM_CYC_LAST) ? 13'h0 : $past(cyc) + 13'h1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_sec; $past(idle) && cyc < $past(cyc) |->
    cyc == 13'h0 && sec == $past(sec) + 7'h1; endproperty
  a_sec: assert property (p_sec) else $error("bad seconds");
  property p_push; i_rx_pkt_valid && !cs_rx |=> o_general_receive_queue_push
    && o_general_receive_queue_data == $past(i_rx_quad); endproperty
  a_push: assert property (p_push) else $error("no push");
  property p_nopush; cs_rx |=> !o_general_receive_queue_push; endproperty
  a_nopush: assert property (p_nopush) else $error("cs pushed");
  property p_start; $rose(o_cycle_flags[ICYTM_STS_CS_BIT]) |->
    $past(i_tx_cs_sent || cs_rx); endproperty
  a_start: assert property (p_start) else $error("stray start");
  property p_req; o_tx_cs_req |-> off <= 12'h1 ##1 !o_tx_cs_req; endproperty
  a_req: assert property (p_req) else $error("bad cs request");
endmodule : icytm_checker
bind icytm_core icytm_checker icytm_checker_inst (.*);
`default_nettype wire

/* File: tb/icytm_link_model.sv */
// Link transmitter and receiver model facing the cycle timer.
// Assumes the core clock; the bench asks it for received packets.
`timescale 1ns/1ps
`default_nettype none
module icytm_link_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_tx_cs_req,
  input  wire logic [3:0]  i_delay,
  output logic             o_cs_sent,
  output logic             o_iso_gap,
  output logic             o_rx_valid,
  output logic      [3:0]  o_rx_tcode,
  output logic      [31:0] o_rx_quad
);
  initial begin
    {o_cs_sent, o_iso_gap, o_rx_valid} = 3'h0;
    o_rx_tcode = 4'h0;
    o_rx_quad = 32'h0;
  end
  // Requested cycle-start goes out after a delay, then iso period ends
  always begin
    @(posedge i_core_clk iff i_tx_cs_req);
    repeat (i_delay + 1) @(negedge i_core_clk);
    o_cs_sent = 1'b1;
    @(negedge i_core_clk) o_cs_sent = 1'b0;
    repeat (4) @(negedge i_core_clk);
    o_iso_gap = 1'b1;
    @(negedge i_core_clk) o_iso_gap = 1'b0;
  end
  // One quadlet per pulse; released data is inverted, not held
  task automatic send(input logic [3:0] tc, input logic [31:0] q);
    @(negedge i_core_clk);
    o_rx_valid = 1'b1;
    o_rx_tcode = tc;
    o_rx_quad = q;
    @(negedge i_core_clk);
    o_rx_valid = 1'b0;
    o_rx_quad = ~q;
  endtask : send
endmodule : icytm_link_model
`default_nettype wire

/* File: tb/icytm_core_tb.sv */
// Self-checking bench of the cycle timer with a link model.
// Assumes icytm_pkg and the checker bound to icytm_core.
`timescale 1ns/1ps
`default_nettype none
module icytm_core_tb;
  import icytm_pkg::*;
  logic i_core_clk, i_nrst, i_reg_wr, i_reg_rd, i_external_cycle_tick_in;
  logic o_reg_ack, i_rx_pkt_valid, o_general_receive_queue_push;
  logic i_tx_cs_sent, i_iso_gap, o_tx_cs_req;
  logic [11:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_rx_quad, o_cycle_time, d, v;
  logic [31:0] o_general_receive_queue_data;
  logic [3:0]  i_rx_tcode, dly;
  logic [2:0]  o_cycle_flags;
  logic [31:0] push_q[$];
  logic [11:0] ofs[6] = '{ICYTM_CFG_OFS, ICYTM_CTL_OFS, ICYTM_STS_OFS,
                          ICYTM_TIM_OFS, ICYTM_TIM2_OFS, 12'hFFC};
  int          n_fail, total_checks, i;
  icytm_core icytm_core_inst (.*);
  icytm_link_model icytm_link_model_inst (.i_core_clk(i_core_clk),
    .i_tx_cs_req(o_tx_cs_req), .i_delay(dly), .o_cs_sent(i_tx_cs_sent),
    .o_iso_gap(i_iso_gap), .o_rx_valid(i_rx_pkt_valid),
    .o_rx_tcode(i_rx_tcode), .o_rx_quad(i_rx_quad));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Strobe for one cycle; an idle cycle follows so strobes never merge
  task automatic wr(input logic [11:0] a, input logic [31:0] q);
    i_reg_addr = a;
    i_reg_wdata = q;
    i_reg_wr = 1'b1;
    @(negedge i_core_clk) i_reg_wr = 1'b0;
    chk(32'(o_reg_ack), 32'h1);
    @(negedge i_core_clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_core_clk) i_reg_rd = 1'b0;
    chk(32'(o_reg_ack), 32'h1);
    q = o_reg_rdata;
    @(negedge i_core_clk);
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Hang guard, well past the longest expected run
  initial begin
    repeat (40000) @(posedge i_core_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    {i_nrst, i_reg_wr, i_reg_rd, i_external_cycle_tick_in} = 4'h0;
    i_reg_addr = 12'h0;
    i_reg_wdata = 32'h0;
    dly = 4'h0;
    v = $urandom(44);
    repeat (8) @(negedge i_core_clk);
    i_nrst = 1'b1;
    // All places read zero after reset, the unmapped one too
    foreach (ofs[k]) begin
      rd(ofs[k], d);
      chk(d, 32'h0);
    end
    v = {7'($urandom), 13'($urandom % 8000), 12'($urandom % 3072)};
    wr(ICYTM_TIM_OFS, v);
    rd(ICYTM_TIM2_OFS, d);
    chk(d, v);
    repeat (40) @(negedge i_core_clk);
    chk(o_cycle_time, v);
    // Seconds wrap from the last offset of the last cycle
    wr(ICYTM_TIM_OFS, {7'h7F, ICYTM_CYC_LAST, 12'hBFA});
    wr(ICYTM_CTL_OFS, 32'h1);
    for (i = 0; o_cycle_time[11:0] > 12'h100 && i < 100; i++)
      @(negedge i_core_clk);
    chk(32'(i < 100), 32'h1);
    chk({12'h0, o_cycle_time[31:12]}, 32'h0);
    v = o_cycle_time;
    repeat (5000) @(negedge i_core_clk);
    d = o_cycle_time - v;
    chk(32'(d inside {[2457:2458]}), 32'h1);
    // Next boundary passes with no cycle-start seen
    for (i = 0; o_cycle_flags[ICYTM_STS_CL_BIT] !== 1'b1 && i < 3000; i++)
      @(negedge i_core_clk);
    chk(32'(i < 3000), 32'h1);
    rd(ICYTM_STS_OFS, d);
    chk(d, 32'h2);
    wr(ICYTM_STS_OFS, 32'h7);
    chk(32'(o_cycle_flags), 32'h0);
    v = {7'($urandom), 13'($urandom % 8000), 12'($urandom % 3072)};
    icytm_link_model_inst.send(ICYTM_TCODE_CS, v);
    chk(o_cycle_time, v);
    chk(32'({o_general_receive_queue_push, o_cycle_flags}), 32'h1);
    push_q.push_back(~v);
    icytm_link_model_inst.send(4'h1, ~v);
    chk(32'(o_general_receive_queue_push), 32'h1);
    chk(o_general_receive_queue_data, push_q.pop_front());
    // Master: wrap requests a cycle-start, model sends it, iso ends
    wr(ICYTM_STS_OFS, 32'h7);
    wr(ICYTM_CTL_OFS, 32'h3);
    for (i = 0; o_tx_cs_req !== 1'b1 && i < 7000; i++)
      @(negedge i_core_clk);
    chk(32'(i < 7000), 32'h1);
    repeat (12) @(negedge i_core_clk);
    chk(32'(o_cycle_flags & 3'h5), 32'h5);
    // Enable and master bits read back as written
    rd(ICYTM_CTL_OFS, d);
    chk(d, 32'h3);
    // External tick as master, slow transmitter
    dly = 4'h9;
    wr(ICYTM_CFG_OFS, 32'h1 << ICYTM_CFG_SRC_BIT);
    rd(ICYTM_CFG_OFS, d);
    chk(d, 32'h1 << ICYTM_CFG_SRC_BIT);
    v = o_cycle_time;
    i_external_cycle_tick_in = 1'b1;
    repeat (8) @(negedge i_core_clk);
    chk(32'(13'(o_cycle_time[24:12] - v[24:12])), 32'h1);
    chk(32'(o_cycle_time[11:0] < 12'h8), 32'h1);
    i_external_cycle_tick_in = 1'b0;
    repeat (20) @(negedge i_core_clk);
    // Master ignores a received cycle-start: no load, no flag, no push
    wr(ICYTM_STS_OFS, 32'h7);
    d = o_cycle_time;
    v = {7'($urandom), 13'($urandom % 8000), 12'($urandom % 3072)};
    icytm_link_model_inst.send(ICYTM_TCODE_CS, v);
    chk({12'h0, o_cycle_time[31:12]}, {12'h0, d[31:12]});
    chk(32'(o_cycle_flags), 32'h0);
    chk(32'(o_general_receive_queue_push), 32'h0);
    print_verdict();
  end
endmodule : icytm_core_tb
`default_nettype wire
